/* ppmt_pkg.sv */
// Package: register map, field layout, field encodings and state type of the port core
package ppmt_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] MODE_OFS     = 8'h10;
  localparam logic [7:0] ADDR_OFS     = 8'h20;
  localparam logic [7:0] DOUT_OFS     = 8'h30;
  localparam logic [7:0] DIN_OFS      = 8'h40;
  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_ON_BIT  = 15;
  localparam int CTRL_CSF_LSB = 6;
  localparam int CTRL_CS2P    = 4;
  localparam int CTRL_CHIP_SELECT_ONE_POLARITY    = 3;
  localparam int CTRL_WRITE_STROBE_POLARITY    = 1;
  localparam int CTRL_READ_STROBE_POLARITY    = 0;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_80DB;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int MODE_BUSY_BIT = 15;
  localparam int MODE_IRQ_LSB  = 13;
  localparam int MODE_INC_LSB  = 11;
  localparam int MODE_WIDE_BIT = 10;
  localparam int MODE_SEL_LSB  = 8;
  localparam int MODE_WB_LSB   = 6;
  localparam int MODE_WM_LSB   = 2;
  localparam int MODE_WE_LSB   = 0;
  localparam logic [31:0] MODE_MASK  = 32'h0000_7FFF;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  // ****************************************************************
  // Field encodings
  // ****************************************************************
  localparam logic [1:0] SEL_LEGACY = 2'h0;
  localparam logic [1:0] SEL_ENH    = 2'h1;
  localparam logic [1:0] SEL_MAST2  = 2'h2;
  localparam logic [1:0] SEL_MAST1  = 2'h3;
  localparam logic [1:0] IRQ_NONE   = 2'h0;
  localparam logic [1:0] IRQ_CYCLE  = 2'h1;
  localparam logic [1:0] IRQ_BUF    = 2'h2;
  localparam logic [1:0] INC_NONE   = 2'h0;
  localparam logic [1:0] INC_UP     = 2'h1;
  localparam logic [1:0] INC_DOWN   = 2'h2;
  localparam logic [1:0] INC_BUF    = 2'h3;
  localparam logic [1:0] CSF_ADDR   = 2'h0;
  localparam logic [1:0] CSF_CS2    = 2'h1;
  localparam logic [1:0] CSF_BOTH   = 2'h2;
  // ****************************************************************
  // Port state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD   = 2'b10
  } ppmt_state_type;
endpackage

/* ppmt_core.sv */
// Parallel port mode, polarity and wait-state core with AHB-Lite registers
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module ppmt_core (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        SLAVE_RD_IN,
  input  wire logic        SLAVE_WR_IN,
  input  wire logic [1:0]  SLAVE_ADDR_IN,
  input  wire logic [15:0] PORT_DATA_IN,
  output logic      [15:0] PORT_DATA_OUT,
  output logic      [15:0] PORT_DATA_OE_OUT,
  output logic      [15:0] PORT_ADDRESS_LINES_OUT,
  output logic             WRITE_STROBE_OUT,
  output logic             READ_STROBE_OUT,
  output logic             ENABLE_STROBE_OUT,
  output logic             DIRECTION_STROBE_OUT,
  output logic             CHIP_SELECT_ONE_OUT,
  output logic             CHIP_SELECT_TWO_OUT,
  output logic             IRQ_OUT,
  output logic      [1:0]  BUF_PTR_OUT
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0]             ctrl;
    logic [31:0]             mode;
    logic [15:0]             addr;
    logic [15:0]             dout;
    logic [15:0]             din;
    logic                    dp_wr;
    logic                    dp_act;
    logic [7:0]              dp_addr;
    logic [31:0]             rdata;
    ppmt_pkg::ppmt_state_type st;
    logic                    is_rd;
    logic [3:0]              cnt;
    logic                    busy;
    logic                    irq;
    logic [1:0]              bptr;
    logic                    sl_rd_d;
    logic                    sl_wr_d;
  } ppmt_regs_type;

  ppmt_regs_type s_r;
  ppmt_regs_type s_nxt;
  logic [1:0]    rst_sync_r;
  logic          rst_n;
  assign rst_n = rst_sync_r[1];

  // ****************************************************************
  // Decoded fields
  // ****************************************************************
  logic       on_bit;
  logic [1:0] sel;
  logic [1:0] irq_mode_field;
  logic [1:0] address_step_mode;
  logic       wide;
  logic [1:0] csf;
  logic [3:0] wm;
  logic [1:0] wb;
  logic [1:0] we;
  logic       master;
  logic       strobe_act;
  logic       cs1_is_cs;
  logic       cs2_is_cs;
  assign on_bit = s_r.ctrl[ppmt_pkg::CTRL_ON_BIT];
  assign sel    = s_r.mode[ppmt_pkg::MODE_SEL_LSB +: 2];
  assign irq_mode_field   = s_r.mode[ppmt_pkg::MODE_IRQ_LSB +: 2];
  assign address_step_mode   = s_r.mode[ppmt_pkg::MODE_INC_LSB +: 2];
  assign wide   = s_r.mode[ppmt_pkg::MODE_WIDE_BIT];
  assign csf    = s_r.ctrl[ppmt_pkg::CTRL_CSF_LSB +: 2];
  assign wm     = s_r.mode[ppmt_pkg::MODE_WM_LSB +: 4];
  assign wb     = s_r.mode[ppmt_pkg::MODE_WB_LSB +: 2];
  assign we     = s_r.mode[ppmt_pkg::MODE_WE_LSB +: 2];
  assign master = (sel == ppmt_pkg::SEL_MAST1) ||
                  (sel == ppmt_pkg::SEL_MAST2);
  assign cs1_is_cs = (csf == ppmt_pkg::CSF_BOTH);
  assign cs2_is_cs = (csf == ppmt_pkg::CSF_BOTH) ||
                     (csf == ppmt_pkg::CSF_CS2);
  assign strobe_act = (s_r.st == ppmt_pkg::ST_STROBE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic        acc_ok;
  logic        abort;
  logic        start;
  logic        start_rd;
  logic        cyc_end;
  logic [31:0] wmask;
  logic [15:0] step_mask;
  logic [15:0] stepped;
  logic [3:0]  setup_cnt;
  logic [3:0]  hold_cnt;
  logic        sl_rd_edge;
  logic        sl_wr_edge;

  always_comb begin
    s_nxt          = s_r;
    abort    = 1'b0;
    acc_ok   = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    start    = 1'b0;
    start_rd = 1'b0;
    cyc_end  = 1'b0;
    wmask    = 32'h0000_0000;
    s_nxt.irq = 1'b0;
    sl_rd_edge = SLAVE_RD_IN && !s_r.sl_rd_d;
    sl_wr_edge = SLAVE_WR_IN && !s_r.sl_wr_d;
    s_nxt.sl_rd_d = SLAVE_RD_IN;
    s_nxt.sl_wr_d = SLAVE_WR_IN;
    // Zero strobe field forces setup one, hold one (wr) or none (rd)
    setup_cnt = (wm == 4'h0) ? 4'h0 : {2'b00, wb};
    if (wm == 4'h0) begin
      hold_cnt = 4'h0;
    end else begin
      hold_cnt = {2'b00, we};
    end
    // Chip-select bits are never stepped
    step_mask = {~cs2_is_cs, ~cs1_is_cs, 14'h3FFF};
    stepped   = s_r.addr;
    // Register write data phase
    if (s_r.dp_act && s_r.dp_wr) begin
      unique case (s_r.dp_addr)
        ppmt_pkg::CTRL_OFS: begin
          s_nxt.ctrl = HWDATA_IN & ppmt_pkg::CTRL_MASK;
          abort      = !HWDATA_IN[ppmt_pkg::CTRL_ON_BIT];
        end
        ppmt_pkg::MODE_OFS: begin
          wmask = ppmt_pkg::MODE_MASK;
          s_nxt.mode = (s_r.mode & ~wmask) | (HWDATA_IN & wmask);
        end
        ppmt_pkg::ADDR_OFS: s_nxt.addr = HWDATA_IN[15:0];
        ppmt_pkg::DOUT_OFS: s_nxt.dout = HWDATA_IN[15:0];
        ppmt_pkg::DIN_OFS: begin
          s_nxt.dout = HWDATA_IN[15:0];
          start = 1'b1;
        end
        default: ;
      endcase
    end
    if (s_r.dp_act && !s_r.dp_wr &&
        s_r.dp_addr == ppmt_pkg::DIN_OFS) begin
      start    = 1'b1;
      start_rd = 1'b1;
    end
    // Address phase capture; answer always zero wait
    s_nxt.dp_act  = acc_ok;
    s_nxt.dp_wr   = HWRITE_IN;
    s_nxt.dp_addr = HADDR_IN[7:0];
    if (acc_ok && !HWRITE_IN) begin
      unique case (HADDR_IN[7:0])
        ppmt_pkg::CTRL_OFS: s_nxt.rdata = s_r.ctrl;
        ppmt_pkg::MODE_OFS: s_nxt.rdata = {s_r.mode[31:16], s_r.busy,
                                           s_r.mode[14:0]};
        ppmt_pkg::ADDR_OFS: s_nxt.rdata = {16'h0000, s_r.addr};
        ppmt_pkg::DOUT_OFS: s_nxt.rdata = {16'h0000, s_r.dout};
        ppmt_pkg::DIN_OFS:  s_nxt.rdata = {16'h0000, s_r.din};
        default:            s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Transfer sequencer
    if (start && on_bit && master && s_r.st == ppmt_pkg::ST_IDLE) begin
      s_nxt.st    = ppmt_pkg::ST_SETUP;
      s_nxt.is_rd = start_rd;
      s_nxt.cnt   = setup_cnt;
      s_nxt.busy  = 1'b1;
    end else begin
      unique case (s_r.st)
        ppmt_pkg::ST_IDLE: ;
        ppmt_pkg::ST_SETUP: begin
          if (s_r.cnt == 4'h0) begin
            s_nxt.st  = ppmt_pkg::ST_STROBE;
            s_nxt.cnt = wm;
          end else begin
            s_nxt.cnt = s_r.cnt - 4'h1;
          end
        end
        ppmt_pkg::ST_STROBE: begin
          if (s_r.cnt == 4'h0) begin
            if (s_r.is_rd) begin
              s_nxt.din = wide ? PORT_DATA_IN
                               : {8'h00, PORT_DATA_IN[7:0]};
            end
            if (s_r.is_rd && hold_cnt == 4'h0) begin
              cyc_end = 1'b1;
            end else begin
              s_nxt.st  = ppmt_pkg::ST_HOLD;
              s_nxt.cnt = s_r.is_rd ? hold_cnt - 4'h1 : hold_cnt;
            end
          end else begin
            s_nxt.cnt = s_r.cnt - 4'h1;
          end
        end
        ppmt_pkg::ST_HOLD: begin
          if (s_r.cnt == 4'h0) begin
            cyc_end = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 4'h1;
          end
        end
      endcase
    end
    if (cyc_end) begin
      s_nxt.st   = ppmt_pkg::ST_IDLE;
      s_nxt.busy = 1'b0;
      if (irq_mode_field == ppmt_pkg::IRQ_CYCLE) begin
        s_nxt.irq = 1'b1;
      end
      if (address_step_mode == ppmt_pkg::INC_UP) begin
        stepped = s_r.addr + 16'h0001;
      end else if (address_step_mode == ppmt_pkg::INC_DOWN) begin
        stepped = s_r.addr - 16'h0001;
      end
      s_nxt.addr = (stepped & step_mask) | (s_r.addr & ~step_mask);
    end
    if (abort || !on_bit) begin
      s_nxt.st   = ppmt_pkg::ST_IDLE;
      s_nxt.busy = 1'b0;
    end
    // Slave side accesses from the external host
    if (on_bit && !master && (sl_rd_edge || sl_wr_edge)) begin
      if (irq_mode_field == ppmt_pkg::IRQ_CYCLE) begin
        s_nxt.irq = 1'b1;
      end
      if (irq_mode_field == ppmt_pkg::IRQ_BUF) begin
        if (sel == ppmt_pkg::SEL_ENH && SLAVE_ADDR_IN == 2'h3) begin
          s_nxt.irq = 1'b1;
        end
        if (sel == ppmt_pkg::SEL_LEGACY && s_r.bptr == 2'h3) begin
          s_nxt.irq = 1'b1;
        end
      end
      if (address_step_mode == ppmt_pkg::INC_BUF && sel == ppmt_pkg::SEL_LEGACY) begin
        s_nxt.bptr = s_r.bptr + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_r.ctrl    <= ppmt_pkg::CTRL_RESET;
      s_r.mode    <= ppmt_pkg::MODE_RESET;
      s_r.addr    <= 16'h0000;
      s_r.dout    <= 16'h0000;
      s_r.din     <= 16'h0000;
      s_r.dp_wr   <= 1'b0;
      s_r.dp_act  <= 1'b0;
      s_r.dp_addr <= 8'h00;
      s_r.rdata   <= 32'h0000_0000;
      s_r.st      <= ppmt_pkg::ST_IDLE;
      s_r.is_rd   <= 1'b0;
      s_r.cnt     <= 4'h0;
      s_r.busy    <= 1'b0;
      s_r.irq     <= 1'b0;
      s_r.bptr    <= 2'h0;
      s_r.sl_rd_d <= 1'b0;
      s_r.sl_wr_d <= 1'b0;
    end else if (CE_IN) begin
      s_r.ctrl    <= s_nxt.ctrl;
      s_r.mode    <= s_nxt.mode;
      s_r.addr    <= s_nxt.addr;
      s_r.dout    <= s_nxt.dout;
      s_r.din     <= s_nxt.din;
      s_r.dp_wr   <= s_nxt.dp_wr;
      s_r.dp_act  <= s_nxt.dp_act;
      s_r.dp_addr <= s_nxt.dp_addr;
      s_r.rdata   <= s_nxt.rdata;
      s_r.st      <= s_nxt.st;
      s_r.is_rd   <= s_nxt.is_rd;
      s_r.cnt     <= s_nxt.cnt;
      s_r.busy    <= s_nxt.busy;
      s_r.irq     <= s_nxt.irq;
      s_r.bptr    <= s_nxt.bptr;
      s_r.sl_rd_d <= s_nxt.sl_rd_d;
      s_r.sl_wr_d <= s_nxt.sl_wr_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic m1;
  logic act_wr;
  logic act_rd;
  assign m1     = (sel == ppmt_pkg::SEL_MAST1);
  assign act_wr = strobe_act && !s_r.is_rd;
  assign act_rd = strobe_act && s_r.is_rd;
  assign HRDATA_OUT    = s_r.rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign IRQ_OUT       = s_r.irq;
  assign BUF_PTR_OUT   = s_r.bptr;
  assign PORT_DATA_OUT = s_r.dout;
  assign PORT_DATA_OE_OUT = (s_r.st != ppmt_pkg::ST_IDLE && !s_r.is_rd)
    ? (wide ? 16'hFFFF : 16'h00FF) : 16'h0000;
  assign PORT_ADDRESS_LINES_OUT = {cs2_is_cs ? 1'b0 : s_r.addr[15],
                                   cs1_is_cs ? 1'b0 : s_r.addr[14],
                                   s_r.addr[13:0]};
  assign WRITE_STROBE_OUT = (!m1 && act_wr) ~^
                            s_r.ctrl[ppmt_pkg::CTRL_WRITE_STROBE_POLARITY];
  assign READ_STROBE_OUT  = (!m1 && act_rd) ~^
                            s_r.ctrl[ppmt_pkg::CTRL_READ_STROBE_POLARITY];
  assign ENABLE_STROBE_OUT = (m1 && strobe_act) ~^
                             s_r.ctrl[ppmt_pkg::CTRL_WRITE_STROBE_POLARITY];
  assign DIRECTION_STROBE_OUT = (m1 && s_r.st != ppmt_pkg::ST_IDLE &&
    s_r.is_rd) ~^ s_r.ctrl[ppmt_pkg::CTRL_READ_STROBE_POLARITY];
  // Pins in address use show the address bit, polarity unused
  assign CHIP_SELECT_ONE_OUT = cs1_is_cs ? ((s_r.st != ppmt_pkg::ST_IDLE
    && s_r.addr[14]) ~^ s_r.ctrl[ppmt_pkg::CTRL_CHIP_SELECT_ONE_POLARITY])
    : s_r.addr[14];
  assign CHIP_SELECT_TWO_OUT = cs2_is_cs ? ((s_r.st != ppmt_pkg::ST_IDLE
    && s_r.addr[15]) ~^ s_r.ctrl[ppmt_pkg::CTRL_CS2P])
    : s_r.addr[15];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);
  a_busy_tracks_fsm: assert property (
    s_r.busy == (s_r.st != ppmt_pkg::ST_IDLE))
    else $error("busy flag disagrees with sequencer");
  a_no_start_off: assert property (
    (CE_IN && !on_bit) |=> s_r.st == ppmt_pkg::ST_IDLE)
    else $error("transfer running while disabled");
  a_strobe_len: assert property (
    (CE_IN && $rose(strobe_act) && wm == 4'h0 && s_r.ctrl[15])
    |=> !strobe_act || !CE_IN)
    else $error("strobe longer than one cycle");
  a_wr_pol: assert property (
    !strobe_act |-> WRITE_STROBE_OUT == !s_r.ctrl[1])
    else $error("idle write strobe wrong level");
  a_rd_pol: assert property (
    !strobe_act |-> READ_STROBE_OUT == !s_r.ctrl[0])
    else $error("idle read strobe wrong level");
  a_en_pol: assert property (
    (m1 && strobe_act) |-> ENABLE_STROBE_OUT == s_r.ctrl[1])
    else $error("enable strobe wrong level");
  a_upper_oe: assert property (
    !wide |-> PORT_DATA_OE_OUT[15:8] == 8'h00)
    else $error("upper data driven in 8-bit");
  a_addr_step: assert property (
    (CE_IN && cyc_end && address_step_mode == ppmt_pkg::INC_UP && csf ==
     ppmt_pkg::CSF_ADDR && !(s_r.dp_act && s_r.dp_wr))
    |=> s_r.addr == $past(s_r.addr) + 16'h0001)
    else $error("address not incremented by one");
endmodule

/* ppmt_peer.sv */
// Far-side peripheral model: answers reads and captures writes
`timescale 1ns/1ns
module ppmt_peer #(
  parameter logic [15:0] RD_VALUE = 16'hA5C3
) (
  input  wire logic        clk_in,
  input  wire logic [1:0]  sel_in,
  input  wire logic        wpol_in,
  input  wire logic        rpol_in,
  input  wire logic        wr_stb_in,
  input  wire logic        rd_stb_in,
  input  wire logic        en_stb_in,
  input  wire logic        dir_stb_in,
  input  wire logic [15:0] dout_in,
  input  wire logic [15:0] oe_in,
  output logic      [15:0] din_out,
  output logic      [15:0] wr_seen_out
);
  logic        m1;
  logic        rd_act;
  logic        wr_act;
  logic [15:0] junk_r = 16'h5A5A;
  assign m1 = (sel_in == ppmt_pkg::SEL_MAST1);
  assign rd_act = m1 ? (en_stb_in == wpol_in && dir_stb_in == rpol_in)
                     : (rd_stb_in == rpol_in);
  assign wr_act = m1 ? (en_stb_in == wpol_in && dir_stb_in != rpol_in)
                     : (wr_stb_in == wpol_in);
  // Released bus shows a pattern that changes every cycle
  assign din_out = rd_act ? RD_VALUE : junk_r;
  always @(posedge clk_in) begin
    junk_r <= ~junk_r;
    if (wr_act) begin
      wr_seen_out <= dout_in & oe_in;
    end
  end
endmodule

/* tb.sv */
// Bench: register access and port transfers of the mode/timing core
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        srd = 1'b0;
  logic        swr = 1'b0;
  logic [1:0]  sadr = '0;
  logic [31:0] hrdata;
  logic        hrdy, hresp, wstb, rstb, estb, dstb, cs1, cs2, irq;
  logic [15:0] pdin, pdout, poe, wseen, pal;
  logic [1:0]  bptr;
  logic [1:0]  sel = '0;
  logic        wp = 1'b0;
  logic        rp = 1'b0;
  logic        cp = 1'b0;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_stb = 0;
  int          n_spn = 0;
  int          n_hi = 0;
  int          n_irq = 0;
  int          n_cs = 0;
  logic [31:0] t_c [5] = '{32'h0000_808B, 32'h0000_8040, 32'h0000_8002,
                           32'h0000_8081, 32'h0000_0003};
  logic [31:0] t_m [5] = '{32'h0000_2A03, 32'h0000_16FF, 32'h0000_2F86,
                           32'h0000_0243, 32'h0000_2A03};
  logic [15:0] t_a [5] = '{16'h7FFF, 16'h8000, 16'h3FFF, 16'h1234, 16'h0010};
  logic        t_r [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #10 clk = ~clk;

  ppmt_core i_ppmt_core (
    .CLK_IN                 (clk),
    .RST_N_IN               (rst_n),
    .CE_IN                  (1'b1),
    .HSEL_IN                (1'b1),
    .HADDR_IN               (haddr),
    .HTRANS_IN              (htrans),
    .HWRITE_IN              (hwrite),
    .HSIZE_IN               (3'b010),
    .HWDATA_IN              (hwdata),
    .HREADY_IN              (hrdy),
    .HRDATA_OUT             (hrdata),
    .HREADYOUT_OUT          (hrdy),
    .HRESP_OUT              (hresp),
    .SLAVE_RD_IN            (srd),
    .SLAVE_WR_IN            (swr),
    .SLAVE_ADDR_IN          (sadr),
    .PORT_DATA_IN           (pdin),
    .PORT_DATA_OUT          (pdout),
    .PORT_DATA_OE_OUT       (poe),
    .PORT_ADDRESS_LINES_OUT (pal),
    .WRITE_STROBE_OUT       (wstb),
    .READ_STROBE_OUT        (rstb),
    .ENABLE_STROBE_OUT      (estb),
    .DIRECTION_STROBE_OUT   (dstb),
    .CHIP_SELECT_ONE_OUT    (cs1),
    .CHIP_SELECT_TWO_OUT    (cs2),
    .IRQ_OUT                (irq),
    .BUF_PTR_OUT            (bptr)
  );

  ppmt_peer #(.RD_VALUE(16'hA5C3)) i_ppmt_peer (
    .clk_in      (clk),
    .sel_in      (sel),
    .wpol_in     (wp),
    .rpol_in     (rp),
    .wr_stb_in   (wstb),
    .rd_stb_in   (rstb),
    .en_stb_in   (estb),
    .dir_stb_in  (dstb),
    .dout_in     (pdout),
    .oe_in       (poe),
    .din_out     (pdin),
    .wr_seen_out (wseen)
  );

  // ****************************************************************
  // Port activity counters
  // ****************************************************************
  always @(posedge clk) begin
    n_stb <= n_stb + int'(sel == 2'h3 ? estb === wp
                          : (wstb === wp || rstb === rp));
    n_spn <= n_spn + int'(poe[0] === 1'b1 || (sel == 2'h3 && dstb === rp));
    n_hi  <= n_hi + int'(poe[8] === 1'b1);
    n_irq <= n_irq + int'(irq === 1'b1);
    n_cs  <= n_cs + int'(cs1 === cp);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    for (int k = 0; k < 9; k++) begin
      @(posedge clk);
      if (hrdy === 1'b1) return;
    end
    n_fail++;
    print_verdict();
  endtask

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic idle(input logic bz);
    logic [31:0] r;
    @(posedge clk);
    bus(ppmt_pkg::MODE_OFS, 1'b0, 32'h0, r);
    if (bz) chk({31'h0, r[15]}, 32'h1);
    for (int k = 0; k < 40 && r[15] !== 1'b0; k++) begin
      bus(ppmt_pkg::MODE_OFS, 1'b0, 32'h0, r);
    end
    if (r[15] !== 1'b0) begin
      n_fail++;
      print_verdict();
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input logic [1:0] a, input logic w);
    sadr <= a;
    srd <= !w;
    swr <= w;
    repeat (3) @(posedge clk);
    srd <= 1'b0;
    swr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic xfer(input int i);
    logic [31:0] c, m, r;
    logic [15:0] na, keep;
    int s0, p0, h0, q0, k0, n;
    c = t_c[i];
    m = t_m[i];
    sel <= m[9:8];
    wp <= c[1];
    rp <= c[0];
    cp <= c[3];
    bus(ppmt_pkg::CTRL_OFS, 1'b1, c, r);
    @(posedge clk);
    bus(ppmt_pkg::MODE_OFS, 1'b1, m, r);
    bus(ppmt_pkg::ADDR_OFS, 1'b1, {16'h0, t_a[i]}, r);
    s0 = n_stb;
    p0 = n_spn;
    h0 = n_hi;
    q0 = n_irq;
    k0 = n_cs;
    bus(ppmt_pkg::DIN_OFS, ~t_r[i], 32'h1234_CD78, r);
    idle(c[15] && m[5:2] != 4'h0);
    n = 0;
    if (c[15]) n = 2 + int'(!t_r[i]) + ((m[5:2] == 4'h0) ? 0
                   : int'(m[7:6]) + int'(m[5:2]) + int'(m[1:0]));
    chk(32'(n_stb - s0), c[15] ? 32'(m[5:2]) + 1 : 0);
    chk(32'(n_spn - p0),
        (t_r[i] && m[9:8] != 2'h3) ? 0 : 32'(n));
    chk(32'(n_hi - h0), (!t_r[i] && m[10]) ? 32'(n) : 0);
    chk(32'(n_irq - q0), {31'h0, c[15] && m[14:13] == 2'h1});
    if (c[7]) chk(32'(n_cs - k0), t_a[i][14] ? 32'(n) : 0);
    keep = c[7] ? 16'hC000 : (c[6] ? 16'h8000 : 16'h0000);
    na = t_a[i];
    if (c[15] && m[12:11] == 2'h1) na = na + 16'h0001;
    if (c[15] && m[12:11] == 2'h2) na = na - 16'h0001;
    na = (t_a[i] & keep) | (na & ~keep);
    bus(ppmt_pkg::ADDR_OFS, 1'b0, 32'h0, r);
    chk(r, {16'h0, na});
    chk({16'h0, pal}, {16'h0, na & ~keep});
    chk({31'h0, cs2}, {31'h0, (c[7] || c[6]) ? ~c[4] : na[15]});
    chk({31'h0, cs1}, {31'h0, c[7] ? ~c[3] : na[14]});
    chk({30'h0, m[9:8] == 2'h3 ? {estb, dstb} : {wstb, rstb}},
        {30'h0, ~c[1:0]});
    if (c[15] && !t_r[i]) chk({16'h0, wseen},
        m[10] ? 32'h0000_CD78 : 32'h0000_0078);
    if (c[15] && t_r[i]) begin
      bus(ppmt_pkg::DIN_OFS, 1'b0, 32'h0, r);
      chk(r, m[10] ? 32'h0000_A5C3 : 32'h0000_00C3);
      idle(1'b0);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    int q;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(ppmt_pkg::CTRL_OFS, 1'b0, 32'h0, r);
    chk(r, 32'h0000_0000);
    bus(ppmt_pkg::MODE_OFS, 1'b0, 32'h0, r);
    chk(r, 32'h0000_0000);
    bus(ppmt_pkg::ADDR_OFS, 1'b0, 32'h0, r);
    chk(r, 32'h0000_0000);
    bus(8'h50, 1'b1, 32'hFFFF_FFFF, r);
    bus(8'h50, 1'b0, 32'h0, r);
    chk(r, 32'h0000_0000);
    bus(ppmt_pkg::MODE_OFS, 1'b1, 32'hFFFF_FFFF, r);
    bus(ppmt_pkg::MODE_OFS, 1'b0, 32'h0, r);
    chk(r, 32'h0000_7FFF);
    bus(ppmt_pkg::CTRL_OFS, 1'b1, 32'hFFFF_7FFF, r);
    bus(ppmt_pkg::CTRL_OFS, 1'b0, 32'h0, r);
    chk(r, 32'h0000_00DB);
    chk({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      xfer(i);
    end
    bus(ppmt_pkg::CTRL_OFS, 1'b1, 32'h0000_8000, r);
    bus(ppmt_pkg::MODE_OFS, 1'b1, 32'h0000_5800, r);
    q = n_irq;
    for (int i = 1; i < 5; i++) begin
      pulse(2'h0, i[0]);
      chk({30'h0, bptr}, 32'(i % 4));
    end
    chk(32'(n_irq - q), 32'h1);
    bus(ppmt_pkg::MODE_OFS, 1'b1, 32'h0000_4100, r);
    q = n_irq;
    pulse(2'h3, 1'b1);
    pulse(2'h1, 1'b0);
    chk(32'(n_irq - q), 32'h1);
    print_verdict();
  end
endmodule
